// ---- logic/spi_eeprom_write_protect_status.sv ----
// Write-protect latch, status register and protection matrix of a serial EEPROM
// How it works
// - Internal writes need the write latch set
// - Set command sets latch, clear command clears
// - Latch clears at reset, clear, status/array write
// - Status read works anytime, even while busy
// - Status: bit7 enable, bits3..2 protect, 1..0 readonly
// - Busy flag reads one only while writing
// - Latch flag mirrors latch, set/clearable only when idle
// - Protect bits change only by status write
// - Protect bits select locked upper address ranges
// - Enable bit nonvolatile, gates protect pin
// - Hardware lock: pin low and enable one
// - Hardware lock blocks only nonvolatile status bits
// - Latch, protect bits and lock form matrix
// - Write starts only on exact chip-select rise
// - Access during internal write is ignored, except status read
// - Starts idle, latch clear, output off
// - Latch commands are opcodes 06h and 04h
// - Latch set needs chip select raised after 8
// - Bits travel most significant first
// - Sample on rising edge, drive after falling
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_write_protect_status #(
  parameter int unsigned WRITE_CYCLES = 100
) (
  // System clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Write-protect pin
  input wire logic wp_n,
  // Array write hand-off and busy
  output logic arr_wr_start,
  output logic [eeprom_prot_pkg::ADDR_W-1:0] arr_wr_addr,
  output logic busy
);
  import eeprom_prot_pkg::*;

  localparam int BW = $clog2(WRITE_CYCLES + 1);
  localparam logic [BW-1:0] LAST_CYCLE = BW'(WRITE_CYCLES - 1);

  // Link domain state
  logic start_r;
  logic long_r;
  logic rd_act_r;
  logic so_r;
  logic [CNT_W-1:0] cnt_r;
  logic [15:0] sh_r;
  logic [15:0] adr_r;
  logic [7:0] op_r;
  logic [7:0] dat_r;
  logic [7:0] out_r;
  logic [7:0] st_s1_r;
  logic [7:0] st_s2_r;

  // System domain state
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;
  logic wp_s1_r;
  logic wp_s2_r;
  // Frame start marker seen from this side: low once the frame has clocked
  logic strt_s1_r;
  logic strt_s2_r;
  logic armed_r;
  logic frame_ok_r;
  logic clocked_r;
  logic wel_r;
  logic wel_nxt;
  logic hpe_r;
  logic [1:0] bp_r;
  logic go_r;
  logic [ADDR_W-1:0] go_addr_r;
  logic [BW-1:0] bcnt_r;
  prog_state_t state_r;
  prog_state_t state_nxt;

  wire [CNT_W-1:0] cur = start_r ? '0 : cnt_r;
  wire [15:0] sh_nxt = {sh_r[14:0], si};
  wire [7:0] stat_byte;

  // Frame start marker, preset while deselected
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      start_r <= 1'b1;
    end else begin
      start_r <= 1'b0;
    end
  end

  // Shift in on the rising edge, most significant bit first
  always_ff @(posedge sck) begin
    sh_r <= sh_nxt;
    cnt_r <= cur + 9'h001;
    long_r <= (long_r & ~start_r) | (cur >= ARR_MIN_LAST);
    st_s1_r <= stat_byte;
    st_s2_r <= st_s1_r;
  end

  always_ff @(posedge sck) begin
    if (cur == OP_LAST) begin
      op_r <= sh_nxt[7:0];
    end
    if (cur == DATA_LAST) begin
      dat_r <= sh_nxt[7:0];
    end
    if (cur == ADDR_LAST) begin
      adr_r <= sh_nxt;
    end
  end

  // Status byte out after falling edges, refreshed every byte
  wire rd_load = ~start_r && cnt_r[2:0] == BYTE_EDGE &&
                 (rd_act_r || (cnt_r == CMD_BITS && ~long_r && op_r == OP_RD_STATUS));
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      rd_act_r <= 1'b0;
      so_r <= 1'b0;
      out_r <= 8'h00;
    end else if (rd_load) begin
      rd_act_r <= 1'b1;
      so_r <= st_s2_r[7];
      out_r <= {st_s2_r[6:0], 1'b0};
    end else begin
      so_r <= out_r[7];
      out_r <= {out_r[6:0], 1'b0};
    end
  end

  assign so = so_r;
  assign so_oe = rd_act_r;

  // Frame decode at chip-select rise
  wire cs_rise = cs_s2_r & ~cs_d_r;
  wire cs_fall = ~cs_s2_r & cs_d_r;
  wire idle = state_r == ST_IDLE;
  // Link fields are read only here, after chip select has risen and while sck
  // stands still; a frame without clocks would otherwise replay stale fields
  wire frame_end = cs_rise & frame_ok_r & clocked_r;
  wire cmd_only = cnt_r == CMD_BITS && ~long_r;
  wire do_set = frame_end & cmd_only & op_r == OP_SET_LATCH & idle;
  wire do_clr = frame_end & cmd_only & op_r == OP_CLR_LATCH & idle;
  wire hw_lock = hpe_r & ~wp_s2_r;
  wire wrs_try = frame_end & cnt_r == WRS_BITS & ~long_r & op_r == OP_WR_STATUS & idle & wel_r;
  wire do_wrs = wrs_try & ~hw_lock;
  wire [ADDR_W-1:0] wr_addr = adr_r[ADDR_W-1:0];
  wire addr_prot = (bp_r == BP_ALL) | (bp_r == BP_HALF && wr_addr >= HALF_BASE) |
                   (bp_r == BP_QTR && wr_addr >= QTR_BASE);
  wire arr_frame = frame_end & long_r & cnt_r[2:0] == BYTE_EDGE & op_r == OP_WR_ARRAY;
  wire do_arr = arr_frame & idle & wel_r & ~addr_prot;
  wire prog_start = do_wrs | do_arr;

  assign stat_byte = {hpe_r, UNUSED_BITS, bp_r, wel_r, busy};
  assign busy = state_r == ST_PROG;

  // Latch: set by its command, cleared by clear, status or array write
  assign wel_nxt = do_set | (wel_r & ~(do_clr | do_wrs | do_arr));

  // Internal write cycle sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (prog_start) begin
          state_nxt = ST_PROG;
        end
      end
      ST_PROG: begin
        if (bcnt_r == LAST_CYCLE) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
      strt_s1_r <= 1'h1;
      strt_s2_r <= 1'h1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
      // Start marker is preset by chip select, so it crosses like a pin
      strt_s1_r <= start_r;
      strt_s2_r <= strt_s1_r;
    end
  end

  // A frame counts only if chip select was seen high first
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      armed_r <= 1'b0;
      frame_ok_r <= 1'b0;
      clocked_r <= 1'h0;
    end else begin
      armed_r <= armed_r | cs_s2_r;
      frame_ok_r <= cs_fall ? armed_r : frame_ok_r;
      // Cleared as a frame opens, set once its first clock is seen
      clocked_r <= (clocked_r & ~cs_fall) | ~strt_s2_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wel_r <= 1'b0;
      hpe_r <= HPE_RESET;
      bp_r <= BP_RESET;
    end else begin
      wel_r <= wel_nxt;
      if (do_wrs) begin
        hpe_r <= dat_r[HPE_BIT];
        bp_r <= {dat_r[BPH_BIT], dat_r[BPL_BIT]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      bcnt_r <= '0;
      go_r <= 1'b0;
      go_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      bcnt_r <= busy ? bcnt_r + 1'b1 : '0;
      go_r <= do_arr;
      if (do_arr) begin
        go_addr_r <= wr_addr;
      end
    end
  end

  assign arr_wr_start = go_r;
  assign arr_wr_addr = go_addr_r;

  // Latch, protection and sequencer checks
  latch_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    do_set |=> wel_r) else $error("latch not set by set command");
  latch_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    (do_clr | prog_start) |=> !wel_r) else $error("latch not cleared");
  write_needs_latch_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(busy) |-> $past(wel_r) && !wel_r) else $error("write cycle without latch");
  hw_lock_a: assert property (@(posedge ref_clk) disable iff (reset)
    (wrs_try && hw_lock) |=> $stable(hpe_r) && $stable(bp_r) && !busy) else $error("locked status changed");
  protect_only_wrs_a: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(do_wrs) |-> $stable(bp_r)) else $error("protect bits changed without status write");
  block_guard_a: assert property (@(posedge ref_clk) disable iff (reset)
    arr_wr_start |-> $past(!addr_prot) && $past(wel_r)) else $error("write to protected block");
  busy_end_a: assert property (@(posedge ref_clk) disable iff (reset)
    (busy && bcnt_r == LAST_CYCLE) |=> !busy ##1 (!busy || $past(prog_start)))
    else $error("busy cycle length wrong");
  busy_ignore_a: assert property (@(posedge ref_clk) disable iff (reset)
    (busy && bcnt_r != LAST_CYCLE) |=> busy && !arr_wr_start) else $error("access during write");
  status_map_a: assert property (@(posedge ref_clk) disable iff (reset)
    stat_byte[WIP_BIT] == busy && stat_byte[WEL_BIT] == wel_r && stat_byte[6:4] == UNUSED_BITS)
    else $error("status layout wrong");
  // The rise is seen one falling edge after the load, so the count is taken from then
  read_after_op_a: assert property (@(negedge sck) disable iff (cs_n)
    $rose(rd_act_r) |-> op_r == OP_RD_STATUS && $past(cnt_r) == CMD_BITS) else $error("status driven early");

  // Frame qualification, refusals and hand-off checks
  standby_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    cs_s2_r |-> !so_oe) else $error("output driven while deselected");
  clockless_frame_a: assert property (@(posedge ref_clk) disable iff (reset)
    (cs_rise && !clocked_r) |=> $stable(wel_r) && !$rose(busy)) else $error("frame without clocks acted");
  latch_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !(do_set || do_clr || prog_start) |=> $stable(wel_r)) else $error("latch changed without command");
  hpe_only_wrs_a: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(do_wrs) |-> $stable(hpe_r)) else $error("enable bit changed without status write");
  start_needs_latch_a: assert property (@(posedge ref_clk) disable iff (reset)
    prog_start |-> wel_r && idle) else $error("write started without latch");
  busy_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    prog_start |=> busy && bcnt_r == '0) else $error("busy cycle did not start");
  start_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    arr_wr_start |=> !arr_wr_start) else $error("write hand-off longer than one cycle");
  addr_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !arr_wr_start |-> $stable(arr_wr_addr)) else $error("write address moved without hand-off");
  wrs_data_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(do_wrs) |-> hpe_r == dat_r[HPE_BIT] && bp_r == {dat_r[BPH_BIT], dat_r[BPL_BIT]})
    else $error("status write took wrong bits");
  busy_refuse_a: assert property (@(posedge ref_clk) disable iff (reset)
    (frame_end && !idle) |=> $stable(wel_r) && $stable(bp_r)) else $error("command acted while busy");

endmodule : spi_eeprom_write_protect_status
`default_nettype wire

// ---- logic/eeprom_prot_pkg.sv ----
// Constants for the serial EEPROM write-protect and status logic
package eeprom_prot_pkg;
  // Instruction bytes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_WR_ARRAY = 8'h02;
  // Status byte layout
  localparam int HPE_BIT = 7;
  localparam int BPH_BIT = 3;
  localparam int BPL_BIT = 2;
  localparam int WEL_BIT = 1;
  localparam int WIP_BIT = 0;
  localparam logic [2:0] UNUSED_BITS = 3'h0;
  // Reset image of the nonvolatile bits
  localparam logic HPE_RESET = 1'b0;
  localparam logic [1:0] BP_RESET = 2'h0;
  // Frame lengths in bits and capture points
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CMD_BITS = 9'h008;
  localparam logic [CNT_W-1:0] WRS_BITS = 9'h010;
  localparam logic [CNT_W-1:0] ARR_MIN_LAST = 9'h01F;
  localparam logic [CNT_W-1:0] OP_LAST = 9'h007;
  localparam logic [CNT_W-1:0] DATA_LAST = 9'h00F;
  localparam logic [CNT_W-1:0] ADDR_LAST = 9'h017;
  localparam logic [2:0] BYTE_EDGE = 3'h0;
  // Array geometry and protection levels
  localparam int ADDR_W = 11;
  localparam logic [ADDR_W-1:0] QTR_BASE = 11'h600;
  localparam logic [ADDR_W-1:0] HALF_BASE = 11'h400;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  // Clock
  localparam int CLK_PERIOD_NS = 50;
  // Internal write cycle sequencer
  typedef enum logic {ST_IDLE = 1'b0, ST_PROG = 1'b1} prog_state_t;
endpackage : eeprom_prot_pkg

// ---- bench/spi_host_model.sv ----
// Host model that drives serial link frames
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Serial link
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // One frame of n bits, then select high for the gap
  task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      #32 sck = 1'b1;
      rx = {rx[6:0], so};
      #32 sck = 1'b0;
    end
    si = ~si;
    cs_n = 1'b1;
    #400;
  endtask : xfer
  // Select pulse with no clocks at all
  task automatic blank_frame();
    cs_n = 1'b0;
    #200 cs_n = 1'b1;
    #400;
  endtask : blank_frame
endmodule : spi_host_model
`default_nettype wire

// ---- bench/spi_eeprom_write_protect_status_tb.sv ----
// Self-checking bench for the write-protect and status logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, a); end end
module spi_eeprom_write_protect_status_tb;
  import eeprom_prot_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wp_n = 1'b1;
  wire sck, cs_n, si, so, so_oe, arr_wr_start, busy;
  wire [ADDR_W-1:0] arr_wr_addr;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int starts = 0;
  logic [ADDR_W-1:0] last_addr = '0;
  logic [7:0] rx;
  always #25 ref_clk = ~ref_clk;
  spi_eeprom_write_protect_status #(.WRITE_CYCLES(100)) dut_u (.ref_clk(ref_clk), .reset(reset), .sck(sck),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .arr_wr_start(arr_wr_start),
    .arr_wr_addr(arr_wr_addr), .busy(busy));
  // Released line shows the inverse of the last bit
  wire so_bus = so_oe ? so : ~so;
  spi_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so_bus));
  // Count write hand-offs and cut a hang short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (arr_wr_start === 1'b1) begin
      starts <= starts + 1;
      last_addr <= arr_wr_addr;
    end
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic cmd(input logic [7:0] op);
    host_u.xfer({24'h0, op}, 8, rx);
  endtask : cmd
  task automatic rd(input logic [7:0] e);
    host_u.xfer({16'h0, OP_RD_STATUS, 8'h00}, 16, rx);
    `CHK("status", e, rx)
    `CHK("so_oe", 1'b0, so_oe)
  endtask : rd
  task automatic write_status_cmd(input logic [7:0] d);
    cmd(OP_SET_LATCH);
    host_u.xfer({16'h0, OP_WR_STATUS, d}, 16, rx);
  endtask : write_status_cmd
  task automatic idle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge ref_clk);
    `CHK("busy", 1'b0, busy)
  endtask : idle
  task automatic arr(input logic [10:0] a, input int n);
    host_u.xfer({OP_WR_ARRAY, 5'h00, a, 8'hA5}, n, rx);
  endtask : arr
  task automatic t_latch();
    `CHK("so_oe", 1'b0, so_oe)
    rd(8'h00);
    cmd(OP_SET_LATCH);
    rd(8'h02);
    cmd(OP_CLR_LATCH);
    rd(8'h00);
    host_u.xfer({23'h0, OP_SET_LATCH, 1'b0}, 9, rx);
    rd(8'h00);
    $display("t_latch done");
  endtask : t_latch
  task automatic t_status();
    host_u.xfer({16'h0, OP_WR_STATUS, 8'h8C}, 16, rx);
    rd(8'h00);
    write_status_cmd(8'hFF);
    `CHK("busy", 1'b1, busy)
    rd(8'h8D);
    idle();
    rd(8'h8C);
    @(posedge ref_clk);
    #5 wp_n = 1'b0;
    write_status_cmd(8'h00);
    rd(8'h8E);
    cmd(OP_CLR_LATCH);
    rd(8'h8C);
    @(posedge ref_clk);
    #5 wp_n = 1'b1;
    write_status_cmd(8'h00);
    cmd(OP_SET_LATCH);
    idle();
    host_u.blank_frame();
    rd(8'h00);
    $display("t_status done");
  endtask : t_status
  task automatic t_array();
    logic [10:0] av [4] = '{11'h5FF, 11'h600, 11'h3FF, 11'h400};
    logic [1:0] bp;
    int n0;
    bit p;
    for (int b = 0; b < 4; b++) begin
      bp = b[1:0];
      write_status_cmd({4'h0, bp, 2'h0});
      idle();
      for (int k = 0; k < 4; k++) begin
        p = (bp == BP_ALL) || (bp == BP_HALF && av[k] >= HALF_BASE) || (bp == BP_QTR && av[k] >= QTR_BASE);
        n0 = starts;
        cmd(OP_SET_LATCH);
        arr(av[k], 32);
        `CHK("starts", p ? 0 : 1, starts - n0)
        if (!p) `CHK("addr", av[k], last_addr)
        idle();
      end
    end
    write_status_cmd(8'h00);
    idle();
    n0 = starts;
    arr(11'h010, 32);
    cmd(OP_SET_LATCH);
    arr(11'h010, 31);
    `CHK("starts", 0, starts - n0)
    arr(11'h010, 32);
    cmd(OP_SET_LATCH);
    arr(11'h020, 32);
    `CHK("starts", 1, starts - n0)
    `CHK("addr", 11'h010, last_addr)
    idle();
    $display("t_array done");
  endtask : t_array
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge ref_clk);
    #5 reset = 1'b0;
    repeat (6) @(posedge ref_clk);
    t_latch();
    t_status();
    t_array();
    finish_test();
  end
endmodule : spi_eeprom_write_protect_status_tb
`default_nettype wire
